// ===== ixp_pkg.sv
package ixp_pkg;
    // ****************************************************************
    // Geometry and bus address
    // ****************************************************************
    localparam int         BANK_W        = 8;
    localparam int         PIN_W         = 16;
    localparam int         SYNC_W        = PIN_W + 4;
    localparam logic [5:0] I2C_ADDR_BASE = 6'h10;

    // ****************************************************************
    // Target register select: {kind, bank}
    // ****************************************************************
    localparam logic [1:0] KIND_IN  = 2'h0;
    localparam logic [1:0] KIND_OUT = 2'h1;
    localparam logic [1:0] KIND_POL = 2'h2;
    localparam logic [1:0] KIND_CFG = 2'h3;
    localparam logic [7:0] RST_OUT  = 8'hFF;
    localparam logic [7:0] RST_POL  = 8'h00;
    localparam logic [7:0] RST_CFG  = 8'hFF;

    // ****************************************************************
    // Local bus registers and events
    // ****************************************************************
    localparam logic [3:0] AV_STAT  = 4'h0;
    localparam logic [3:0] AV_MASK  = 4'h4;
    localparam logic [3:0] AV_PINS  = 4'h8;
    localparam int         EV_W     = 3;
    localparam int         EV_CHG   = 0;
    localparam int         EV_WR    = 1;
    localparam int         EV_RST   = 2;

    // ****************************************************************
    // Serial target states, Gray along the usual path
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_ACK  = 3'b011,
        ST_TX   = 3'b010,
        ST_MACK = 3'b110
    } ixp_state_e;
endpackage : ixp_pkg

// ===== ixp_sync_if.sv
`timescale 1ns/10ps
// ********************************************************************
// Raw pins in, synchronised levels out
// ********************************************************************
interface ixp_sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport syn (input raw, output sync);
    modport usr (output raw, input sync);
endinterface : ixp_sync_if

// ===== ixp_sync.sv
`timescale 1ns/10ps
module ixp_sync #(
    parameter int W = 1
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    ixp_sync_if.syn   port
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s1_d;
    logic [W-1:0] s2_q;
    logic [W-1:0] s2_d;

    // ****************************************************************
    // Two-stage synchroniser
    // ****************************************************************
    // Only the second stage is read outside
    always_comb begin
        s1_d = port.raw;
        s2_d = s1_q;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign port.sync = s2_q;
endmodule : ixp_sync

// ===== ixp_expander_top.sv
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
module ixp_expander_top #(
    parameter logic [5:0] ADDR_BASE = ixp_pkg::I2C_ADDR_BASE
) (
    input  wire logic                      clk_sys_in,
    input  wire logic                      rst_in,
    input  wire logic [3:0]                avs_address_in,
    input  wire logic                      avs_read_in,
    input  wire logic                      avs_write_in,
    input  wire logic [31:0]               avs_writedata_in,
    output logic      [31:0]               avs_readdata_out,
    output logic                           avs_waitrequest_out,
    output logic                           irq_out,
    input  wire logic                      scl_in,
    input  wire logic                      sda_in,
    output logic                           sda_out,
    output logic                           sda_oe_out,
    input  wire logic                      reset_n_in,
    input  wire logic                      addr_sel_in,
    input  wire logic [ixp_pkg::PIN_W-1:0] io_pin_bank_in,
    output logic      [ixp_pkg::PIN_W-1:0] io_pin_bank_out,
    output logic      [ixp_pkg::PIN_W-1:0] io_pin_bank_oe_out,
    output logic                           int_n_out,
    output logic                           int_n_oe_out
);
    import ixp_pkg::*;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    ixp_sync_if #(.W(SYNC_W)) sy_if ();

    // Every pin from outside passes two flops first
    assign sy_if.raw = {io_pin_bank_in, addr_sel_in, reset_n_in,
                        sda_in, scl_in};

    ixp_sync #(
        .W      (SYNC_W)
    ) u_sync (
        .clk_in (clk_sys_in),
        .rst_in (rst_in),
        .port   (sy_if.syn)
    );

    logic              scl_s;
    logic              sda_s;
    logic              rstn_s;
    logic              addr_s;
    logic [PIN_W-1:0]  pin_s;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;
    logic              soft_rst;

    assign scl_s  = sy_if.sync[0];
    assign sda_s  = sy_if.sync[1];
    assign rstn_s = sy_if.sync[2];
    assign addr_s = sy_if.sync[3];
    assign pin_s  = sy_if.sync[SYNC_W-1:4];

    // ****************************************************************
    // Register state
    // ****************************************************************
    ixp_state_e        st_q, st_d;
    logic [2:0]        cnt_q, cnt_d;
    logic [7:0]        sh_q, sh_d;
    logic [1:0]        byte_q, byte_d;
    logic              rw_q, rw_d;
    logic              done_q, done_d;
    logic              nack_q, nack_d;
    logic [2:0]        ptr_q, ptr_d;
    logic              oe_q, oe_d;
    logic              scl_p_q, scl_p_d;
    logic              sda_p_q, sda_p_d;
    logic              cap_q, cap_d;
    logic              wr_ev_q, wr_ev_d;
    logic              chg_q, chg_d;
    logic [1:0][7:0]   out_q, out_d;
    logic [1:0][7:0]   pol_q, pol_d;
    logic [1:0][7:0]   cfg_q, cfg_d;
    logic [1:0][7:0]   in_q, in_d;
    logic              rd_now;

    // Edges seen on the synchronised serial lines
    assign scl_rise  = scl_s & ~scl_p_q;
    assign scl_fall  = ~scl_s & scl_p_q;
    assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign soft_rst  = ~rstn_s;

    // Byte returned for a register select
    function automatic logic [7:0] rd_byte(
        input logic [2:0]      sel,
        input logic [1:0][7:0] pin,
        input logic [1:0][7:0] out,
        input logic [1:0][7:0] pol,
        input logic [1:0][7:0] cfg
    );
        logic [7:0] v;
        v = 8'h00;
        case (sel[2:1])
            KIND_IN:  v = pin[sel[0]] ^ pol[sel[0]];
            KIND_OUT: v = out[sel[0]];
            KIND_POL: v = pol[sel[0]];
            KIND_CFG: v = cfg[sel[0]];
            default:  v = 8'h00;
        endcase
        return v;
    endfunction : rd_byte

    // ****************************************************************
    // Serial target and its register file
    // ****************************************************************
    // Sampling at 50 MHz gives wide margin on a 2.5 us fast-mode clock
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        byte_d  = byte_q;
        rw_d    = rw_q;
        done_d  = done_q;
        nack_d  = nack_q;
        ptr_d   = ptr_q;
        oe_d    = oe_q;
        out_d   = out_q;
        pol_d   = pol_q;
        cfg_d   = cfg_q;
        in_d    = in_q;
        scl_p_d = scl_s;
        sda_p_d = sda_s;
        cap_d   = 1'b0;
        wr_ev_d = 1'b0;
        rd_now  = 1'b0;
        // Input change seen only on pins set as inputs
        chg_d   = |((pin_s ^ in_q) & cfg_q);
        if (cap_q) begin
            in_d = pin_s;
        end
        case (st_q)
            ST_IDLE: begin
                oe_d = 1'b0;
            end
            ST_RX: begin
                if (scl_rise) begin
                    sh_d   = {sh_q[6:0], sda_s};
                    cnt_d  = cnt_q + 3'd1;
                    done_d = (cnt_q == 3'd7);
                end else if (scl_fall && done_q) begin
                    done_d = 1'b0;
                    oe_d   = 1'b1;
                    st_d   = ST_ACK;
                    byte_d = (byte_q == 2'd2) ? 2'd2 : byte_q + 2'd1;
                    if (byte_q == 2'd0) begin
                        rw_d = sh_q[0];
                        // Unmatched address: stay silent until start
                        if (sh_q[7:1] != {ADDR_BASE, addr_s}) begin
                            oe_d = 1'b0;
                            st_d = ST_IDLE;
                        end
                    end else if (byte_q == 2'd1) begin
                        ptr_d = sh_q[2:0];
                    end else begin
                        // Data bytes alternate within a bank pair
                        ptr_d   = ptr_q ^ 3'd1;
                        wr_ev_d = 1'b1;
                        case (ptr_q[2:1])
                            KIND_OUT: out_d[ptr_q[0]] = sh_q;
                            KIND_POL: pol_d[ptr_q[0]] = sh_q;
                            KIND_CFG: cfg_d[ptr_q[0]] = sh_q;
                            default:  ;
                        endcase
                    end
                end
            end
            ST_ACK: begin
                if (scl_fall) begin
                    if (rw_q) begin
                        rd_now = 1'b1;
                    end else begin
                        oe_d  = 1'b0;
                        cnt_d = 3'd0;
                        st_d  = ST_RX;
                    end
                end
            end
            ST_TX: begin
                if (scl_fall) begin
                    if (cnt_q == 3'd7) begin
                        oe_d = 1'b0;
                        st_d = ST_MACK;
                    end else begin
                        sh_d  = {sh_q[6:0], 1'b0};
                        oe_d  = ~sh_q[6];
                        cnt_d = cnt_q + 3'd1;
                    end
                end
            end
            ST_MACK: begin
                if (scl_rise) begin
                    nack_d = sda_s;
                end else if (scl_fall) begin
                    if (nack_q) begin
                        st_d = ST_IDLE;
                    end else begin
                        rd_now = 1'b1;
                    end
                end
            end
            default: begin
                st_d = ST_IDLE;
                oe_d = 1'b0;
            end
        endcase
        // Load a read byte and latch the input bank being read
        if (rd_now) begin
            sh_d  = rd_byte(ptr_q, pin_s, out_q, pol_q, cfg_q);
            oe_d  = ~sh_d[7];
            cnt_d = 3'd0;
            st_d  = ST_TX;
            ptr_d = ptr_q ^ 3'd1;
            if (ptr_q[2:1] == KIND_IN) begin
                in_d[ptr_q[0]] = pin_s[ptr_q[0]*BANK_W +: BANK_W];
            end
        end
        // Start restarts the framing; repeated start keeps the pointer
        if (start_det) begin
            st_d   = ST_RX;
            cnt_d  = 3'd0;
            byte_d = 2'd0;
            done_d = 1'b0;
            oe_d   = 1'b0;
        end else if (stop_det) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
        end
        // Reset pin acts as power-on reset without losing power
        if (soft_rst) begin
            st_d   = ST_IDLE;
            oe_d   = 1'b0;
            done_d = 1'b0;
            ptr_d  = 3'd0;
            out_d  = {RST_OUT, RST_OUT};
            pol_d  = {RST_POL, RST_POL};
            cfg_d  = {RST_CFG, RST_CFG};
            cap_d  = 1'b1;
        end
    end

    // Power-on reset loads defaults and idles the target
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st_q    <= ST_IDLE;
            cnt_q   <= 3'd0;
            sh_q    <= 8'h00;
            byte_q  <= 2'd0;
            rw_q    <= 1'b0;
            done_q  <= 1'b0;
            nack_q  <= 1'b0;
            ptr_q   <= 3'd0;
            oe_q    <= 1'b0;
            scl_p_q <= 1'b0;
            sda_p_q <= 1'b0;
            cap_q   <= 1'b1;
            wr_ev_q <= 1'b0;
            chg_q   <= 1'b0;
            out_q   <= {RST_OUT, RST_OUT};
            pol_q   <= {RST_POL, RST_POL};
            cfg_q   <= {RST_CFG, RST_CFG};
            in_q    <= '0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            byte_q  <= byte_d;
            rw_q    <= rw_d;
            done_q  <= done_d;
            nack_q  <= nack_d;
            ptr_q   <= ptr_d;
            oe_q    <= oe_d;
            scl_p_q <= scl_p_d;
            sda_p_q <= sda_p_d;
            cap_q   <= cap_d;
            wr_ev_q <= wr_ev_d;
            chg_q   <= chg_d;
            out_q   <= out_d;
            pol_q   <= pol_d;
            cfg_q   <= cfg_d;
            in_q    <= in_d;
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    // Open drain lines only ever pull low; never a bus initiator
    assign sda_out            = 1'b0;
    assign sda_oe_out         = oe_q;
    assign int_n_out          = 1'b0;
    assign int_n_oe_out       = chg_q;
    assign io_pin_bank_out    = out_q;
    assign io_pin_bank_oe_out = ~cfg_q;

    // ****************************************************************
    // Local bus slave with sticky status and mask
    // ****************************************************************
    logic [EV_W-1:0]   stat_q, stat_d;
    logic [EV_W-1:0]   mask_q, mask_d;
    logic [EV_W-1:0]   ev;
    logic              ack_q, ack_d;
    logic [31:0]       rdat_q, rdat_d;
    logic              chg_p_q, chg_p_d;
    logic              srst_p_q, srst_p_d;
    logic              req;

    assign req = avs_read_in | avs_write_in;

    // One wait cycle per access; read data is registered
    always_comb begin
        ev         = '0;
        ev[EV_CHG] = chg_q & ~chg_p_q;
        ev[EV_WR]  = wr_ev_q;
        ev[EV_RST] = soft_rst & ~srst_p_q;
        chg_p_d    = chg_q;
        srst_p_d   = soft_rst;
        ack_d      = req & ~ack_q;
        rdat_d     = rdat_q;
        mask_d     = mask_q;
        stat_d     = stat_q;
        if (req && !ack_q) begin
            case (avs_address_in)
                AV_STAT: rdat_d = {{(32-EV_W){1'b0}}, stat_q};
                AV_MASK: rdat_d = {{(32-EV_W){1'b0}}, mask_q};
                AV_PINS: rdat_d = {15'h0000, chg_q, pin_s};
                default: rdat_d = 32'h0000_0000;
            endcase
        end
        if (ack_q && avs_write_in && avs_address_in == AV_MASK) begin
            mask_d = avs_writedata_in[EV_W-1:0];
        end
        // Read clears status; a new event in that cycle still lands
        if (ack_q && avs_read_in && avs_address_in == AV_STAT) begin
            stat_d = '0;
        end
        stat_d = stat_d | ev;
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            stat_q   <= '0;
            mask_q   <= '0;
            ack_q    <= 1'b0;
            rdat_q   <= 32'h0000_0000;
            chg_p_q  <= 1'b0;
            srst_p_q <= 1'b0;
        end else begin
            stat_q   <= stat_d;
            mask_q   <= mask_d;
            ack_q    <= ack_d;
            rdat_q   <= rdat_d;
            chg_p_q  <= chg_p_d;
            srst_p_q <= srst_p_d;
        end
    end

    assign avs_readdata_out    = rdat_q;
    assign avs_waitrequest_out = req & ~ack_q;
    assign irq_out             = |(stat_q & mask_q);
endmodule : ixp_expander_top

// ===== ixp_props.sv
`timescale 1ns/10ps
module ixp_props (
    input wire logic        clk_sys_in,
    input wire logic        rst_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        irq_out,
    input wire logic        scl_in,
    input wire logic        sda_out,
    input wire logic        sda_oe_out,
    input wire logic        reset_n_in,
    input wire logic [15:0] io_pin_bank_out,
    input wire logic [15:0] io_pin_bank_oe_out,
    input wire logic        int_n_out,
    input wire logic        int_n_oe_out
);
    // ****
    // Port checks, one clock domain
    // ****
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence s_req; $rose(avs_read_in || avs_write_in); endsequence
    sequence s_ans; avs_waitrequest_out ##1 !avs_waitrequest_out; endsequence
    sequence s_pin_rst; !reset_n_in [*5]; endsequence
    property p_one_wait; s_req |-> s_ans; endproperty
    property p_idle; !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out;
    endproperty
    property p_por_pins; $fell(rst_in) |-> io_pin_bank_oe_out == 16'h0000;
    endproperty
    property p_por_bus; $fell(rst_in) |-> !irq_out && !sda_oe_out &&
        avs_readdata_out == 32'h0 && io_pin_bank_out == 16'hFFFF; endproperty
    property p_pin_rst; s_pin_rst |-> io_pin_bank_oe_out == 16'h0000 &&
        io_pin_bank_out == 16'hFFFF && !sda_oe_out; endproperty
    // Eight quiet high clock cycles mean no byte can be landing
    property p_hold; (scl_in && reset_n_in) [*8] |->
        $stable(io_pin_bank_out) && $stable(io_pin_bank_oe_out); endproperty
    property p_no_init; scl_in [*8] |-> !sda_oe_out; endproperty
    property p_open_drain; sda_out == 1'b0 && int_n_out == 1'b0; endproperty
    property p_all_out; (io_pin_bank_oe_out == 16'hFFFF) [*8] |->
        !int_n_oe_out; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait");
    a_idle: assert property (p_idle) else $error("idle wait");
    a_por_pins: assert property (p_por_pins) else $error("por pins");
    a_por_bus: assert property (p_por_bus) else $error("por bus");
    a_pin_rst: assert property (p_pin_rst) else $error("pin reset");
    a_hold: assert property (p_hold) else $error("latch hold");
    a_no_init: assert property (p_no_init) else $error("sda drive");
    a_open_drain: assert property (p_open_drain) else $error("od");
    a_all_out: assert property (p_all_out) else $error("int");
endmodule : ixp_props
bind ixp_expander_top ixp_props u_props (.clk_sys_in, .rst_in,
    .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out,
    .irq_out, .scl_in, .sda_out, .sda_oe_out, .reset_n_in,
    .io_pin_bank_out, .io_pin_bank_oe_out, .int_n_out, .int_n_oe_out);

// ===== ixp_host.sv
`timescale 1ns/10ps
module ixp_host (
    input  wire logic clk_sys_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_oe_out
);
    // ****
    // Bus master, SCL period 8 clocks, stands high between frames
    // ****
    initial begin
        scl_out    = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : wt
    // Also a repeated START; waits for the target to drop its ACK
    task automatic start();
        wt(2);
        sda_oe_out <= 1'b0;
        wt(4);
        scl_out <= 1'b1;
        wt(4);
        sda_oe_out <= 1'b1;
        wt(4);
        scl_out <= 1'b0;
    endtask : start
    task automatic stop();
        wt(2);
        sda_oe_out <= 1'b1;
        wt(2);
        scl_out <= 1'b1;
        wt(4);
        sda_oe_out <= 1'b0;
        wt(4);
    endtask : stop
    // Nine bits MSB first; a 1 releases the line so reads work too
    task automatic xbyte(input logic [7:0] d, input logic a,
                         output logic [7:0] q, output logic ack);
        logic [8:0] t;
        t = {d, a};
        for (int i = 8; i >= 0; i--) begin
            wt(2);
            sda_oe_out <= ~t[i];
            wt(2);
            scl_out <= 1'b1;
            wt(4);
            t[i] = sda_in;
            scl_out <= 1'b0;
        end
        q   = t[8:1];
        ack = t[0];
    endtask : xbyte
endmodule : ixp_host

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import ixp_pkg::*;
    localparam logic [7:0] DEV = {I2C_ADDR_BASE, 2'h2}; // Strap high
    logic        clk_sys_in, rst_in, avs_read_in, avs_write_in, reset_n_in;
    logic        addr_sel_in, irq_out, sda_oe_out, int_n_out, int_n_oe_out;
    logic        avs_waitrequest_out, sda_out, scl, host_sda_oe;
    logic [3:0]  avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, r;
    logic [15:0] io_pin_bank_out, io_pin_bank_oe_out, ext;
    logic [7:0]  r0, r1;
    int          checked, err_count, cyc;
    // Pull-up on SDA; driven pins show their latch, others the board
    wire logic        sda_line = (sda_oe_out ? sda_out : 1'b1) & ~host_sda_oe;
    // Interrupt wire with its pull-up, as the host would see it
    wire logic        int_line = int_n_oe_out ? int_n_out : 1'b1;
    wire logic [15:0] pins = (io_pin_bank_oe_out & io_pin_bank_out) |
                             (~io_pin_bank_oe_out & ext);
    ixp_expander_top uut (.clk_sys_in, .rst_in, .avs_address_in,
        .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
        .avs_waitrequest_out, .irq_out, .scl_in(scl), .sda_in(sda_line),
        .sda_out, .sda_oe_out, .reset_n_in, .addr_sel_in,
        .io_pin_bank_in(pins), .io_pin_bank_out, .io_pin_bank_oe_out,
        .int_n_out, .int_n_oe_out);
    ixp_host host (.clk_sys_in, .sda_in(sda_line), .scl_out(scl),
                   .sda_oe_out(host_sda_oe));
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    // Hang guard, well above the few thousand cycles the tests take
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Avalon master: hold everything until waitrequest is seen low
    task automatic av(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        @(posedge clk_sys_in);
        avs_read_in      <= ~w;
        avs_write_in     <= w;
        avs_address_in   <= a;
        avs_writedata_in <= d;
        // Only the hang guard ends a wait that never sees an answer
        do begin
            @(posedge clk_sys_in);
        end while (avs_waitrequest_out !== 1'b0);
        r = avs_readdata_out;
        avs_read_in  <= 1'b0;
        avs_write_in <= 1'b0;
    endtask : av
    task automatic wr2(input logic [7:0] a, s, d0, d1, input logic [3:0] ek);
        logic [7:0] q;
        logic [3:0] k;
        host.start();
        host.xbyte(a, 1'b1, q, k[3]);
        host.xbyte(s, 1'b1, q, k[2]);
        host.xbyte(d0, 1'b1, q, k[1]);
        host.xbyte(d1, 1'b1, q, k[0]);
        host.stop();
        chk("wr ack", {28'h0, k}, {28'h0, ek});
    endtask : wr2
    task automatic rd2(input logic [7:0] s);
        logic [7:0] q;
        logic [4:0] k;
        host.start();
        host.xbyte(DEV, 1'b1, q, k[0]);
        host.xbyte(s, 1'b1, q, k[1]);
        host.start();
        host.xbyte(DEV | 8'h01, 1'b1, q, k[2]);
        host.xbyte(8'hFF, 1'b0, r0, k[3]);
        host.xbyte(8'hFF, 1'b1, r1, k[4]);
        host.stop();
        chk("rd ack", {29'h0, k[2:0]}, 32'h0);
    endtask : rd2
    initial begin
        rst_in = 1'b1;
        reset_n_in = 1'b1;
        addr_sel_in = 1'b1;
        ext = 16'h0000;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_address_in = 4'h0;
        avs_writedata_in = 32'h0;
        repeat (10) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        chk("oe", {16'h0, io_pin_bank_oe_out}, 32'h0);
        chk("out", {16'h0, io_pin_bank_out}, 32'hFFFF);
        av(1'b0, AV_STAT, 32'h0);
        chk("stat", r, 32'h4);
        av(1'b0, AV_STAT, 32'h0);
        chk("stat clr", r, 32'h0);
        av(1'b1, 4'hC, 32'hFFFFFFFF);
        av(1'b0, 4'hC, 32'h0);
        chk("unmapped", r, 32'h0);
        $display("test defaults done");
        wr2(8'h20, 8'h06, 8'h00, 8'hF0, 4'hF);
        chk("oe nack", {16'h0, io_pin_bank_oe_out}, 32'h0);
        wr2(DEV, 8'h06, 8'h00, 8'hF0, 4'h0);
        wr2(DEV, 8'h02, 8'hA5, 8'h3C, 4'h0);
        host.wt(8);
        chk("oe", {16'h0, io_pin_bank_oe_out}, 32'h0FFF);
        chk("out", {16'h0, io_pin_bank_out}, 32'h3CA5);
        av(1'b0, AV_STAT, 32'h0);
        chk("stat wr", r, 32'h2);
        rd2(8'h06);
        chk("cfg", {16'h0, r1, r0}, 32'hF000);
        rd2(8'h02);
        chk("outreg", {16'h0, r1, r0}, 32'h3CA5);
        $display("test serial done");
        av(1'b1, AV_MASK, 32'h1);
        wr2(DEV, 8'h05, 8'h30, 8'h00, 4'h0);
        host.wt(8);
        chk("irq masked", {31'h0, irq_out}, 32'h0);
        ext <= 16'hA000;
        for (int i = 0; i < 20 && int_n_oe_out !== 1'b1; i++) begin
            @(posedge clk_sys_in);
        end
        chk("int", {31'h0, int_line}, 32'h0);
        av(1'b0, AV_PINS, 32'h0);
        chk("pins", r, 32'h0001ACA5);
        chk("irq", {31'h0, irq_out}, 32'h1);
        av(1'b0, AV_STAT, 32'h0);
        chk("stat int", r, 32'h3);
        host.wt(3);
        chk("irq clr", {31'h0, irq_out}, 32'h0);
        rd2(8'h01);
        chk("inreg", {16'h0, r0, r1}, 32'h9CA5);
        host.wt(8);
        chk("int clr", {31'h0, int_line}, 32'h1);
        rd2(8'h04);
        chk("pol", {16'h0, r1, r0}, 32'h3000);
        $display("test polarity done");
        wr2(DEV, 8'h06, 8'h00, 8'h00, 4'h0);
        host.wt(30);
        chk("latch", {16'h0, io_pin_bank_out}, 32'h3CA5);
        reset_n_in <= 1'b0;
        host.wt(8);
        chk("rst oe", {16'h0, io_pin_bank_oe_out}, 32'h0);
        chk("rst out", {16'h0, io_pin_bank_out}, 32'hFFFF);
        reset_n_in <= 1'b1;
        host.wt(8);
        rd2(8'h06);
        chk("rst cfg", {16'h0, r1, r0}, 32'hFFFF);
        rd2(8'h04);
        chk("rst pol", {16'h0, r1, r0}, 32'h0);
        av(1'b0, AV_STAT, 32'h0);
        chk("stat rst", r & 32'h4, 32'h4);
        $display("test reset pin done");
        // Strap moved only while the device is held in reset
        reset_n_in <= 1'b0;
        addr_sel_in <= 1'b0;
        host.wt(8);
        reset_n_in <= 1'b1;
        host.wt(8);
        wr2(DEV, 8'h06, 8'h00, 8'h00, 4'hF);
        wr2({I2C_ADDR_BASE, 2'h0}, 8'h06, 8'h0F, 8'hFF, 4'h0);
        host.wt(8);
        chk("strap low", {16'h0, io_pin_bank_oe_out}, 32'h00F0);
        $display("test strap done");
        end_sim();
    end
endmodule : tb_top
